/* capd_pkg.sv */
// shared constants and types for the capacity LED display and init block
package capd_pkg;

   // register map: serial command register
   localparam logic [7:0] RESET_CMD_ADDR   = 8'h00;
   localparam logic [7:0] RESET_CMD_VALUE  = 8'h78;

   // preset values loaded at initialization
   localparam logic [7:0] CAC_LOW_INIT     = 8'h00;
   localparam logic [7:0] REL_FULL_INIT    = 8'h64;
   localparam logic [7:0] REL_EMPTY_INIT   = 8'h00;
   localparam logic [7:0] FLAGS_FULL_INIT  = 8'h90;
   localparam logic [7:0] FLAGS_EMPTY_INIT = 8'h10;
   localparam logic [7:0] ZERO_BYTE        = 8'h00;

   // percentage band limits
   localparam logic [6:0] PCT_SCALE        = 7'd100;
   localparam logic [6:0] INC_LED_SEGMENT_FOUR_PCT     = 7'd90;
   localparam logic [6:0] INC_LED_SEGMENT_THREE_PCT     = 7'd50;
   localparam logic [6:0] INC_LED_SEGMENT_TWO_PCT     = 7'd20;
   localparam logic [6:0] BIN_BOTH_PCT     = 7'd70;
   localparam logic [6:0] BIN_ONE_PCT      = 7'd40;
   localparam logic [6:0] BIN_TWO_PCT      = 7'd10;
   localparam logic [6:0] BAR_FIVE_PCT     = 7'd80;
   localparam logic [6:0] BAR_FOUR_PCT     = 7'd60;
   localparam logic [6:0] BAR_THREE_PCT    = 7'd40;
   localparam logic [6:0] BAR_TWO_PCT      = 7'd20;

   // timing: clock and millisecond time base
   localparam int CLK_PERIOD_NS  = 20;
   localparam int TICK_NS        = 1000000;
   localparam int TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S       = 1000;
   // display on-time after request
   localparam int SHOW_ON_S      = 4;
   localparam int INC_ON_S       = 10;
   localparam int SHOW_ON_MS     = SHOW_ON_S * MS_PER_S;
   localparam int INC_ON_MS      = INC_ON_S * MS_PER_S;
   // bank modulation
   localparam int BANK_HZ        = 100;
   localparam int BANK_DUTY_PCT  = 30;
   localparam int BANK_PERIOD_MS = MS_PER_S / BANK_HZ;
   localparam int BANK_ON_MS     = BANK_PERIOD_MS * BANK_DUTY_PCT / 100;
   localparam int BANK_B_START   = BANK_PERIOD_MS / 2;
   // low-battery blink
   localparam int BLINK_HZ       = 4;
   localparam int BLINK_HALF_MS  = MS_PER_S / (2 * BLINK_HZ);

   // synchronised pin positions
   localparam int PIN_REQ_N    = 0;
   localparam int PIN_MODE_HI  = 1;
   localparam int PIN_MODE_LO  = 2;
   localparam int PIN_FILL     = 3;
   localparam logic [3:0] PIN_SYNC_RESET = 4'h1;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_SHOW = 2'b11
   } capd_state_t;

   typedef enum logic [1:0] {
      MODE_INCR = 2'b00,
      MODE_BIN  = 2'b01,
      MODE_BAR  = 2'b10
   } capd_mode_t;

endpackage : capd_pkg

/* capd_tick_if.sv */
// carries the millisecond time-base tick between modules
`timescale 1ns/10ps
interface capd_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface : capd_tick_if

/* capd_tick_gen.sv */
// periodic one-cycle tick generator
`timescale 1ns/10ps
module capd_tick_gen #(
   parameter int CYC = capd_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rstn,
   // tick out
   capd_tick_if.src    tk
);

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } capd_tick_st_t;

   capd_tick_st_t cur_ff;
   capd_tick_st_t nxt_ff;

   always_comb
   begin
      nxt_ff      = cur_ff;
      nxt_ff.tick = 1'b0;
      if (cur_ff.cnt == 32'(CYC - 1))
      begin
         nxt_ff.cnt  = 32'h0;
         nxt_ff.tick = 1'b1;
      end
      else
      begin
         nxt_ff.cnt = cur_ff.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   assign tk.tick = cur_ff.tick;

endmodule : capd_tick_gen

/* capd_led_display.sv */
// capacity LED display driver with init presets and reset command
// Overview of operation
// - Incremental mode lights exactly one of segments one to four by the 90/50/20 percent bands.
// - A high mode pin selects binary mode on segments one and two only.
// - Binary mode shows both on from 70, one only from 40, two only from 10, none below 10.
// - A floating mode pin selects bar graph mode, one more segment per 20 percent band.
// - In bar and incremental modes the first empty warning blinks segment one, others off.
// - In binary and bar modes a low display request keeps segments active 4 s, then off.
// - Writing 78h to the command register at 00h runs the full initialization.
// - Init with fill pin high loads full count into full reference and high byte, 64h, 90h.
// - Init with fill pin low clears reference, both bytes and relative charge, flags 10h.
// - Percent is capacity over full reference; incremental mode stays active 10 s.
// - Segments one, three, five and two, four alternate as banks at 100 Hz, 30 percent each.
// - The low-battery blink of segment one runs at 4 Hz, toggling every 125 ms, while the first warning is set in bar and incremental modes.
// - The final empty warning disables every segment in every mode.
`timescale 1ns/10ps
module capd_led_display #(
   parameter int TICK_CYC      = capd_pkg::TICK_CYC,
   parameter int SHOW_ON_MS    = capd_pkg::SHOW_ON_MS,
   parameter int INC_ON_MS     = capd_pkg::INC_ON_MS,
   parameter int BLINK_HALF_MS = capd_pkg::BLINK_HALF_MS
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // pins from outside
   input  wire logic       display_request_n,
   input  wire logic       display_mode_select_pin_hi,
   input  wire logic       display_mode_select_pin_lo,
   input  wire logic       init_fill_select_pin,
   // serial command write from the host port decoder
   input  wire logic       cmd_wr,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [7:0] cmd_data,
   // gauge state
   input  wire logic [7:0] programmed_full_count,
   input  wire logic [7:0] comp_capacity_now,
   input  wire logic       first_empty_warning,
   input  wire logic       final_empty_warning,
   // LED pins
   output logic [4:0]      led_segment_oe_n,
   output logic            led_common_output,
   // initialized registers
   output logic [7:0]      full_capacity_reference,
   output logic [7:0]      comp_capacity_high_byte,
   output logic [7:0]      comp_capacity_low_byte,
   output logic [7:0]      relative_charge,
   output logic [7:0]      flags_one,
   output logic            init_done
);

   typedef struct packed {
      logic [3:0]           sync1;
      logic [3:0]           sync2;
      logic                 req_prev;
      capd_pkg::capd_state_t st;
      capd_pkg::capd_mode_t  mode;
      logic [7:0]           full;
      logic [7:0]           cap_hi;
      logic [7:0]           cap_lo;
      logic [7:0]           rel;
      logic [7:0]           flags;
      logic [13:0]          timer;
      logic [3:0]           phase;
      logic [7:0]           blink_cnt;
      logic                 blink;
      logic [4:0]           seg_oe_n;
      logic                 com;
      logic                 init_pulse;
   } capd_state_st_t;

   capd_state_st_t cur_ff;
   capd_state_st_t nxt_ff;

   capd_tick_if ms_if ();

   capd_tick_gen #(
      .CYC  (TICK_CYC)
   ) u_ms_tick (
      .clk  (clk),
      .rstn (rstn),
      .tk   (ms_if.src)
   );

   // capacity at or above pct percent of the full reference
   function automatic logic pct_ge(input logic [7:0] cac, input logic [7:0] full,
                                   input logic [6:0] pct);
      logic [15:0] lhs;
      logic [15:0] rhs;
      lhs = 16'(cac) * 16'(capd_pkg::PCT_SCALE);
      rhs = 16'(full) * 16'(pct);
      return lhs >= rhs;
   endfunction : pct_ge

   logic [4:0] seg_on;
   logic       bank_a;
   logic       bank_b;
   logic       req_fall;
   logic       reset_cmd;
   logic [7:0] cac;

   always_comb
   begin
      cac       = comp_capacity_now;
      req_fall  = cur_ff.req_prev & ~cur_ff.sync2[capd_pkg::PIN_REQ_N];
      reset_cmd = cmd_wr && (cmd_addr == capd_pkg::RESET_CMD_ADDR)
                  && (cmd_data == capd_pkg::RESET_CMD_VALUE);
      bank_a    = cur_ff.phase < 4'(capd_pkg::BANK_ON_MS);
      bank_b    = (cur_ff.phase >= 4'(capd_pkg::BANK_B_START))
                  && (cur_ff.phase < 4'(capd_pkg::BANK_B_START + capd_pkg::BANK_ON_MS));
      seg_on    = 5'h00;
      case (cur_ff.mode)
         capd_pkg::MODE_INCR:
         begin
            if (first_empty_warning)
               seg_on = {4'h0, cur_ff.blink};
            else if (pct_ge(cac, cur_ff.full, capd_pkg::INC_LED_SEGMENT_FOUR_PCT))
               seg_on = 5'h08;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::INC_LED_SEGMENT_THREE_PCT))
               seg_on = 5'h04;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::INC_LED_SEGMENT_TWO_PCT))
               seg_on = 5'h02;
            else
               seg_on = 5'h01;
         end
         capd_pkg::MODE_BIN:
         begin
            if (pct_ge(cac, cur_ff.full, capd_pkg::BIN_BOTH_PCT))
               seg_on = 5'h03;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BIN_ONE_PCT))
               seg_on = 5'h01;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BIN_TWO_PCT))
               seg_on = 5'h02;
            else
               seg_on = 5'h00;
         end
         capd_pkg::MODE_BAR:
         begin
            if (first_empty_warning)
               seg_on = {4'h0, cur_ff.blink};
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BAR_FIVE_PCT))
               seg_on = 5'h1F;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BAR_FOUR_PCT))
               seg_on = 5'h0F;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BAR_THREE_PCT))
               seg_on = 5'h07;
            else if (pct_ge(cac, cur_ff.full, capd_pkg::BAR_TWO_PCT))
               seg_on = 5'h03;
            else
               seg_on = 5'h01;
         end
         default:
         begin
            seg_on = 5'h00;
         end
      endcase
      if (final_empty_warning)
         seg_on = 5'h00;
   end

   always_comb
   begin
      nxt_ff            = cur_ff;
      nxt_ff.sync1      = {init_fill_select_pin, display_mode_select_pin_lo,
                           display_mode_select_pin_hi, display_request_n};
      nxt_ff.sync2      = cur_ff.sync1;
      nxt_ff.req_prev   = cur_ff.sync2[capd_pkg::PIN_REQ_N];
      nxt_ff.init_pulse = 1'b0;

      // millisecond time base: bank phase and blink
      if (ms_if.snk.tick)
      begin
         if (cur_ff.phase == 4'(capd_pkg::BANK_PERIOD_MS - 1))
            nxt_ff.phase = 4'h0;
         else
            nxt_ff.phase = cur_ff.phase + 4'h1;
         if (cur_ff.blink_cnt == 8'(BLINK_HALF_MS - 1))
         begin
            nxt_ff.blink_cnt = 8'h00;
            nxt_ff.blink     = ~cur_ff.blink;
         end
         else
         begin
            nxt_ff.blink_cnt = cur_ff.blink_cnt + 8'h01;
         end
      end

      case (cur_ff.st)
         capd_pkg::ST_INIT:
         begin
            if (cur_ff.sync2[capd_pkg::PIN_MODE_HI])
               nxt_ff.mode = capd_pkg::MODE_BIN;
            else if (cur_ff.sync2[capd_pkg::PIN_MODE_LO])
               nxt_ff.mode = capd_pkg::MODE_INCR;
            else
               nxt_ff.mode = capd_pkg::MODE_BAR;
            if (cur_ff.sync2[capd_pkg::PIN_FILL])
            begin
               nxt_ff.full   = programmed_full_count;
               nxt_ff.cap_hi = programmed_full_count;
               nxt_ff.cap_lo = capd_pkg::CAC_LOW_INIT;
               nxt_ff.rel    = capd_pkg::REL_FULL_INIT;
               nxt_ff.flags  = capd_pkg::FLAGS_FULL_INIT;
            end
            else
            begin
               nxt_ff.full   = capd_pkg::ZERO_BYTE;
               nxt_ff.cap_hi = capd_pkg::ZERO_BYTE;
               nxt_ff.cap_lo = capd_pkg::ZERO_BYTE;
               nxt_ff.rel    = capd_pkg::REL_EMPTY_INIT;
               nxt_ff.flags = capd_pkg::FLAGS_EMPTY_INIT;
            end
            nxt_ff.timer      = 14'h0;
            nxt_ff.init_pulse = 1'b1;
            nxt_ff.st         = capd_pkg::ST_IDLE;
         end
         capd_pkg::ST_IDLE, capd_pkg::ST_SHOW:
         begin
            if (cur_ff.st == capd_pkg::ST_SHOW && ms_if.snk.tick)
            begin
               if (cur_ff.timer <= 14'h1)
                  nxt_ff.st = capd_pkg::ST_IDLE;
               nxt_ff.timer = cur_ff.timer - 14'h1;
            end
            if (req_fall)
            begin
               nxt_ff.st = capd_pkg::ST_SHOW;
               if (cur_ff.mode == capd_pkg::MODE_INCR)
                  nxt_ff.timer = 14'(INC_ON_MS);
               else
                  nxt_ff.timer = 14'(SHOW_ON_MS);
            end
            if (reset_cmd)
               nxt_ff.st = capd_pkg::ST_INIT;
         end
         default:
         begin
            nxt_ff.st = capd_pkg::ST_INIT;
         end
      endcase

      // drive low only while showing and the segment's bank is active
      if (cur_ff.st == capd_pkg::ST_SHOW)
      begin
         nxt_ff.seg_oe_n = ~(seg_on & {bank_a, bank_b, bank_a, bank_b, bank_a});
         nxt_ff.com      = 1'b1;
      end
      else
      begin
         nxt_ff.seg_oe_n = 5'h1F;
         nxt_ff.com      = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cur_ff          <= '0;
         cur_ff.sync1    <= capd_pkg::PIN_SYNC_RESET;
         cur_ff.sync2    <= capd_pkg::PIN_SYNC_RESET;
         cur_ff.req_prev <= 1'b1;
         cur_ff.st       <= capd_pkg::ST_INIT;
         cur_ff.mode     <= capd_pkg::MODE_BAR;
         cur_ff.seg_oe_n <= 5'h1F;
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   assign led_segment_oe_n        = cur_ff.seg_oe_n;
   assign led_common_output       = cur_ff.com;
   assign full_capacity_reference = cur_ff.full;
   assign comp_capacity_high_byte = cur_ff.cap_hi;
   assign comp_capacity_low_byte  = cur_ff.cap_lo;
   assign relative_charge         = cur_ff.rel;
   assign flags_one               = cur_ff.flags;
   assign init_done               = cur_ff.init_pulse;

endmodule : capd_led_display

/* capd_led_display_chk.sv */
// assertion checker for the capacity LED display block
`timescale 1ns/10ps
module capd_led_display_chk #(
   parameter int TICK_CYC      = 10,
   parameter int SHOW_ON_MS    = 5,
   parameter int INC_ON_MS     = 8,
   parameter int BLINK_HALF_MS = 3
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // inputs watched
   input wire logic       display_request_n,
   input wire logic       cmd_wr,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic       final_empty_warning,
   // outputs watched
   input wire logic [4:0] led_segment_oe_n,
   input wire logic       led_common_output,
   input wire logic [7:0] full_capacity_reference,
   input wire logic [7:0] comp_capacity_high_byte,
   input wire logic [7:0] comp_capacity_low_byte,
   input wire logic [7:0] relative_charge,
   input wire logic [7:0] flags_one,
   input wire logic       init_done
);
   localparam int MAX_MS = (INC_ON_MS > SHOW_ON_MS) ? INC_ON_MS : SHOW_ON_MS;
   localparam int LIM    = MAX_MS * TICK_CYC + TICK_CYC + 8;
   logic       cmd_ok;
   logic [4:0] on;
   int         span_ff;
   int         nxt_span;
   assign cmd_ok = cmd_wr && cmd_addr == capd_pkg::RESET_CMD_ADDR
                   && cmd_data == capd_pkg::RESET_CMD_VALUE;
   assign on = ~led_segment_oe_n;
   // length of the present show, restarted by a new request
   always_comb nxt_span = (led_common_output && display_request_n) ? span_ff + 1 : 0;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         span_ff <= 0;
      else
         span_ff <= nxt_span;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_cmd_starts_init:
   assert property (cmd_ok && !$past(cmd_ok) |-> ##2 init_done)
      else $error("reset command did not start init");
   chk_init_has_cause:
   assert property (init_done |-> $past(cmd_ok, 2) || !$past(rstn, 2))
      else $error("init without command or reset");
   chk_fill_high_presets:
   assert property (init_done && flags_one == capd_pkg::FLAGS_FULL_INIT |->
      relative_charge == capd_pkg::REL_FULL_INIT && comp_capacity_low_byte == 8'h00
      && comp_capacity_high_byte == full_capacity_reference)
      else $error("full presets wrong");
   chk_fill_low_presets:
   assert property (init_done && flags_one == capd_pkg::FLAGS_EMPTY_INIT |->
      (full_capacity_reference | comp_capacity_high_byte | comp_capacity_low_byte
      | relative_charge) == 8'h00)
      else $error("empty presets wrong");
   chk_final_blanks_all:
   assert property (final_empty_warning [*2] |-> &led_segment_oe_n)
      else $error("segment lit under final warning");
   chk_banks_apart:
   assert property (!((on[0] || on[2] || on[4]) && (on[1] || on[3])))
      else $error("both banks lit together");
   chk_dark_when_idle:
   assert property (!led_common_output |-> &led_segment_oe_n)
      else $error("segment lit while display idle");
   chk_request_shows:
   assert property ($fell(display_request_n) |-> ##[2:6] led_common_output)
      else $error("request did not start display");
   chk_show_span_bound:
   assert property (span_ff <= LIM)
      else $error("display stayed on too long");
endmodule : capd_led_display_chk

bind capd_led_display capd_led_display_chk #(
   .TICK_CYC(TICK_CYC), .SHOW_ON_MS(SHOW_ON_MS), .INC_ON_MS(INC_ON_MS),
   .BLINK_HALF_MS(BLINK_HALF_MS)
) i_capd_led_display_chk (.clk, .rstn, .display_request_n, .cmd_wr, .cmd_addr, .cmd_data,
   .final_empty_warning, .led_segment_oe_n, .led_common_output, .full_capacity_reference,
   .comp_capacity_high_byte, .comp_capacity_low_byte, .relative_charge, .flags_one,
   .init_done);

/* capd_led_load.sv */
// LED load model: senses segment pins and records which segments lit
`timescale 1ns/10ps
module capd_led_load (
   // clock
   input  wire logic       clk,
   // LED pins from the block
   input  wire logic [4:0] led_segment_oe_n,
   input  wire logic       led_common_output,
   // observation
   input  wire logic       clr,
   output logic [4:0]      lit_mask
);
   logic [4:0] seg_level;
   // released pin sits high through the LED; driven pin sits low
   assign seg_level = led_segment_oe_n;
   always @(posedge clk)
      if (clr)
         lit_mask <= 5'h00;
      else
         lit_mask <= lit_mask | (~seg_level & {5{led_common_output}});
endmodule : capd_led_load

/* capd_led_display_test.sv */
// self-checking bench for the capacity LED display block
`timescale 1ns/10ps
module capd_led_display_test;
   localparam int TK  = 10;
   localparam int DON = 25;
   localparam int ION = 30;
   logic       clk, rstn, req_n, m_hi, m_lo, fill, wr, w1, wf, com, done, clr;
   logic [7:0] addr, data, full_cnt, cac, full, cap_hi, cap_lo, rel, flg;
   logic [4:0] oe, lit;
   int         fail_count;
   int         tests_run;
   logic [7:0] bar_c [7] = '{8'hC8, 8'hA0, 8'h9F, 8'h78, 8'h50, 8'h28, 8'h27};
   logic [4:0] bar_m [7] = '{5'h1F, 5'h1F, 5'h0F, 5'h0F, 5'h07, 5'h03, 5'h01};
   logic [7:0] bin_c [4] = '{8'h8C, 8'h50, 8'h14, 8'h13};
   logic [4:0] bin_m [4] = '{5'h03, 5'h01, 5'h02, 5'h00};
   logic [7:0] inc_c [5] = '{8'hB4, 8'hB3, 8'h64, 8'h28, 8'h27};
   logic [4:0] inc_m [5] = '{5'h08, 5'h04, 5'h04, 5'h02, 5'h01};

   capd_led_display #(.TICK_CYC(TK), .SHOW_ON_MS(DON), .INC_ON_MS(ION), .BLINK_HALF_MS(3))
   i_capd_led_display (.clk(clk), .rstn(rstn), .display_request_n(req_n),
      .display_mode_select_pin_hi(m_hi), .display_mode_select_pin_lo(m_lo),
      .init_fill_select_pin(fill), .cmd_wr(wr), .cmd_addr(addr), .cmd_data(data),
      .programmed_full_count(full_cnt), .comp_capacity_now(cac), .first_empty_warning(w1),
      .final_empty_warning(wf), .led_segment_oe_n(oe), .led_common_output(com),
      .full_capacity_reference(full), .comp_capacity_high_byte(cap_hi),
      .comp_capacity_low_byte(cap_lo), .relative_charge(rel), .flags_one(flg),
      .init_done(done));

   capd_led_load i_capd_led_load (.clk(clk), .led_segment_oe_n(oe),
      .led_common_output(com), .clr(clr), .lit_mask(lit));

   task end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task write_cmd(input logic [7:0] a, input logic [7:0] d, input logic exp);
      logic seen;
      seen = 1'b0;
      tick(4);
      {wr, addr, data} = {1'b1, a, d};
      tick(1);
      wr = 1'b0;
      repeat (4)
      begin
         tick(1);
         seen = seen | done;
      end
      check("init_done", 8'(seen), 8'(exp));
   endtask : write_cmd

   task mode(input logic hi, input logic lo);
      {m_hi, m_lo} = {hi, lo};
      write_cmd(8'h00, 8'h78, 1'b1);
   endtask : mode

   task show(input logic [7:0] c, input logic [4:0] m, input int ms);
      int n;
      cac = c;
      clr = 1'b1;
      req_n = 1'b0;
      tick(3);
      {clr, req_n} = 2'b01;
      n = 0;
      while (com !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      n = 0;
      while (com === 1'b1 && n < 2000)
      begin
         tick(1);
         n++;
      end
      check("lit", 8'(lit), 8'(m));
      check("span", 8'(n >= (ms - 1) * TK && n <= (ms + 1) * TK), 8'h01);
   endtask : show

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      fail_count = 0;
      tests_run = 0;
      {rstn, wr, m_hi, m_lo, fill, w1, wf, clr} = 8'h00;
      {req_n, addr, data, full_cnt, cac} = {1'b1, 32'h0000_0000};
      tick(16);
      check("oe_rst", 8'(oe), 8'h1F);
      rstn = 1'b1;
      tick(4);
      check("flags_lo", flg, 8'h10);
      check("full_lo", full, 8'h00);
      write_cmd(8'h01, 8'h78, 1'b0);
      write_cmd(8'h00, 8'h77, 1'b0);
      {full_cnt, fill} = {8'hC8, 1'b1};
      mode(1'b0, 1'b0);
      check("full", full, 8'hC8);
      check("cap_hi", cap_hi, 8'hC8);
      check("cap_lo", cap_lo, 8'h00);
      check("rel", rel, 8'h64);
      check("flags", flg, 8'h90);
      for (int i = 0; i < 7; i++)
         show(bar_c[i], bar_m[i], DON);
      w1 = 1'b1;
      show(8'hC8, 5'h01, DON);
      {w1, wf} = 2'b01;
      show(8'hC8, 5'h00, DON);
      {wf, m_hi} = 2'b01;
      show(8'hC8, 5'h1F, DON);
      mode(1'b1, 1'b0);
      for (int i = 0; i < 4; i++)
         show(bin_c[i], bin_m[i], DON);
      w1 = 1'b1;
      show(8'hC8, 5'h03, DON);
      w1 = 1'b0;
      mode(1'b0, 1'b1);
      for (int i = 0; i < 5; i++)
         show(inc_c[i], inc_m[i], ION);
      w1 = 1'b1;
      show(8'hC8, 5'h01, ION);
      {w1, fill} = 2'b00;
      mode(1'b0, 1'b1);
      check("flags_lo2", flg, 8'h10);
      check("rel_lo", rel, 8'h00);
      end_of_test();
   end
endmodule : capd_led_display_test
